// File: core/query_pkg.sv
// Shared constants and carriers for the serial query handler
package query_pkg;
   // Function codes
   localparam logic [7:0] FN_RD_COILS  = 8'h01;
   localparam logic [7:0] FN_RD_REGS   = 8'h03;
   localparam logic [7:0] FN_WR_COIL   = 8'h05;
   localparam logic [7:0] FN_WR_REG    = 8'h06;
   localparam logic [7:0] FN_LOOPBACK  = 8'h08;
   localparam logic [7:0] FN_WR_COILS  = 8'h0F;
   localparam logic [7:0] FN_EXC_FLAG  = 8'h80;
   // Exception codes
   localparam logic [7:0] EXC_FUNC     = 8'h01;
   localparam logic [7:0] EXC_ADDR     = 8'h02;
   localparam logic [7:0] EXC_DATA     = 8'h03;
   // Coil change data
   localparam logic [7:0] COIL_ON_HI   = 8'hFF;
   localparam logic [7:0] COIL_LO      = 8'h00;
   // Limits
   localparam int         MAX_COILS    = 32;
   localparam int         MAX_REGS     = 4;
   localparam logic [7:0] RUN_SRC_LINK = 8'h03;
   // CRC preset and reflected generator
   localparam logic [15:0] CRC_PRESET  = 16'hFFFF;
   localparam logic [15:0] CRC_POLY_R  = 16'hA001;
   // Silent interval: 3.5 characters of 11 bits at default baud
   localparam int         BAUD_DEFAULT = 9600;
   localparam int         CLK_HZ       = 125_000_000;
   localparam int         SILENT_BITS_X2 = 77;
   localparam int         SILENT_CYC =
      (SILENT_BITS_X2 * (CLK_HZ / BAUD_DEFAULT) + 1) / 2;
   // One byte with its frame markers
   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       last;
   } byte_s;
endpackage : query_pkg

// File: core/query_handler.sv
// Parses buffered query frames and emits response frames with CRC
`timescale 1ns/10ps
// What this block does
// [R1] Read coils: addr, fn, count, data, CRC
// [R2] Zero or over 32 coils gives 03h
// [R3] First coil sits in LSB
// [R4] Coils beyond range report zero
// [R5] Broadcast queries ignored, never answered
// [R6] Start number plus one selects item
// [R7] Read consecutive holding registers from start
// [R8] Byte count doubles; registers high first
// [R9] Sixteen-bit fields sent high byte first
// [R10] FF00 switches coil on, 0000 off
// [R11] Coil write echoes query or exception
// [R12] Run coil acts only with source 03
// [R13] Register write stores then echoes query
// [R14] Loopback only subcode 0000, echoed
// [R15] Failed coil read gives exception
// [R16] Multiple coil write updates consecutive coils
// [R17] Frames end with CRC-16
// [R18] Exception fn is query fn plus 80h
// [R19] Wait silent interval plus extra wait, summed in an 18-bit counter (default SILENT exceeds 18 bits)
// [R20] Bad frames dropped without answer
// [R21] CRC preset ones, LSB first, reflected
module query_handler
   import query_pkg::*;
#(
   parameter int NUM_COILS = 32,             // Defined coil range
   parameter int NUM_REGS  = 16,             // Holding registers kept here
   parameter int SILENT    = SILENT_CYC      // Silent interval in cycles
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  slave_addr,      // Own station address
   input  wire logic [7:0]  run_command_source, // 03 selects the link
   input  wire logic [15:0] response_extra_wait, // Extra wait in cycles
   input  wire byte_s       rx_byte,         // Received byte with markers
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic        rx_error,        // Framing/parity/gap seen
   output byte_s            tx_byte,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [NUM_COILS-1:0] coils,       // Coil image
   output logic             run_cmd          // Run coil as it reaches drive
);
   initial begin
      if (NUM_COILS < 2 || NUM_COILS > 256 || NUM_REGS < 1 || NUM_REGS > 256)
         $error("query_handler: unsupported size");
   end

   typedef enum {S_RX, S_EXEC, S_WAIT, S_TX} state_e;

   // Two-entry skid buffer on the receive path
   byte_s      buf_q [2];                    // Buffer slots
   logic [1:0] buf_cnt;                      // Occupancy
   logic       pop;                          // Parser takes a byte
   assign rx_ready = (buf_cnt != 2'd2);
   wire   push = rx_valid && rx_ready;

   // Buffer occupancy and shift
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_cnt <= 2'd0;
      end else begin
         buf_cnt <= 2'(buf_cnt + {1'b0, push} - {1'b0, pop});
      end
   end
   always_ff @(posedge clk) begin
      if (pop) begin
         buf_q[0] <= (buf_cnt == 2'd2) ? buf_q[1] : rx_byte;
      end else if (push && buf_cnt == 2'd0) begin
         buf_q[0] <= rx_byte;
      end
      if (push && ((buf_cnt == 2'd1 && !pop) || (buf_cnt == 2'd2 && pop))) begin
         buf_q[1] <= rx_byte;
      end
   end

   state_e      state_reg;
   logic [7:0]  q_reg [12];                  // Query bytes
   logic [3:0]  qlen_reg;                    // Query byte count
   logic        bad_reg;                     // Overrun or error seen
   logic [15:0] crc_reg;                     // Running CRC
   logic [15:0] crc_d1_reg, crc_d2_reg, tail_reg; // CRC before last bytes, last two bytes
   logic [7:0]  r_reg [12];                  // Response bytes
   logic [3:0]  rlen_reg;                    // Response length without CRC
   logic [3:0]  ridx_reg;                    // Transmit index
   logic [17:0] wait_reg;                    // Silent wait counter
   logic [15:0] hreg [NUM_REGS];             // Holding registers

   assign pop = (state_reg == S_RX) && (buf_cnt != 2'd0);

   // One CRC byte step, LSB first with reflected polynomial
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] t;
      t = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++)
         t = t[0] ? ((t >> 1) ^ CRC_POLY_R) : (t >> 1);
      return t;
   endfunction : crc_step

   // Decoded query fields; the wire start is one below the item [R6]
   wire [7:0]  fn    = q_reg[1];
   wire [15:0] start = {q_reg[2], q_reg[3]};                 // [R9]
   wire [15:0] cnt   = {q_reg[4], q_reg[5]};                 // [R9]
   wire [16:0] first = {1'b0, start} + 17'd1;                // [R6]
   wire        addr_ok = (q_reg[0] == slave_addr) && (q_reg[0] != 8'h00); // [R5]
   // Check word arrives high byte first, so the residue trick fails; compare instead
   wire [15:0] crc_fin = crc_d2_reg ^ tail_reg;              // [R17] [R21]
   wire [3:0]  exp_len =
      (fn == FN_WR_COILS) ? 4'(7 + q_reg[6] + 2) : 4'd8;
   wire        frame_ok = !bad_reg && addr_ok && (crc_fin == 16'h0000)
                          && (qlen_reg == exp_len);          // [R20] [R17]

   // Coil read packing, beyond range reads zero [R3] [R4]
   logic [31:0] coil_pack;
   always_comb begin
      coil_pack = 32'h0000_0000;
      for (int i = 0; i < MAX_COILS; i++) begin
         if (i < cnt && (int'(first) - 1 + i) < NUM_COILS)
            coil_pack[i] = coils[int'(first) - 1 + i];
      end
   end

   // Response being formed
   logic [7:0] resp [12];
   logic [3:0] resp_len;
   logic       wr_coil, wr_reg, wr_coils;
   logic [7:0] nbytes;
   always_comb begin
      for (int i = 0; i < 12; i++)
         resp[i] = q_reg[i];                                 // Echo by default [R11] [R13]
      resp_len = 4'd6;
      wr_coil  = 1'b0;
      wr_reg   = 1'b0;
      wr_coils = 1'b0;
      nbytes   = 8'((cnt + 16'd7) >> 3);
      case (fn)
         FN_RD_COILS: begin
            if (cnt == 16'd0 || cnt > MAX_COILS) begin
               resp[2] = EXC_DATA;                           // [R2] [R15]
               resp_len = 4'd3;
            end else begin
               resp[2] = nbytes;                             // [R1]
               for (int b = 0; b < 4; b++)
                  resp[3+b] = coil_pack[8*b +: 8];           // [R1] [R3]
               resp_len = 4'(3 + nbytes);
            end
         end
         FN_RD_REGS: begin
            if (cnt == 16'd0 || cnt > MAX_REGS) begin
               resp[2] = EXC_DATA;
               resp_len = 4'd3;
            end else if (32'(first) + 32'(cnt) - 1 > NUM_REGS) begin
               resp[2] = EXC_ADDR;
               resp_len = 4'd3;
            end else begin
               resp[2] = 8'(cnt << 1);                       // [R8]
               for (int k = 0; k < MAX_REGS; k++) begin
                  resp[3+2*k] = hreg[(int'(start) + k) % NUM_REGS][15:8]; // [R7] [R8]
                  resp[4+2*k] = hreg[(int'(start) + k) % NUM_REGS][7:0];
               end
               resp_len = 4'(3 + (cnt << 1));
            end
         end
         FN_WR_COIL: begin
            if (first > NUM_COILS) begin
               resp[2] = EXC_ADDR;
               resp_len = 4'd3;
            end else if (q_reg[5] != COIL_LO
                         || (q_reg[4] != COIL_ON_HI && q_reg[4] != COIL_LO)) begin
               resp[2] = EXC_DATA;                           // [R10] [R11]
               resp_len = 4'd3;
            end else begin
               wr_coil = 1'b1;
            end
         end
         FN_WR_REG: begin
            if (first > NUM_REGS) begin
               resp[2] = EXC_ADDR;
               resp_len = 4'd3;
            end else begin
               wr_reg = 1'b1;                                // [R13]
            end
         end
         FN_LOOPBACK: begin
            if (start != 16'h0000) begin
               resp[2] = EXC_DATA;                           // [R14]
               resp_len = 4'd3;
            end
         end
         FN_WR_COILS: begin
            if (cnt == 16'd0 || cnt > MAX_COILS || q_reg[6] != nbytes) begin
               resp[2] = EXC_DATA;
               resp_len = 4'd3;
            end else if (32'(first) + 32'(cnt) - 1 > NUM_COILS) begin
               resp[2] = EXC_ADDR;
               resp_len = 4'd3;
            end else begin
               wr_coils = 1'b1;                              // [R16]
            end
         end
         default: begin
            resp[2] = EXC_FUNC;
            resp_len = 4'd3;
         end
      endcase
      if (resp_len == 4'd3)
         resp[1] = fn | FN_EXC_FLAG;                         // [R18]
   end

   // Next coil image from writes
   logic [NUM_COILS-1:0] coils_next;
   wire  [31:0]          wdata = {q_reg[10], q_reg[9], q_reg[8], q_reg[7]};
   always_comb begin
      coils_next = coils;
      if (wr_coil)
         coils_next[int'(start)] = (q_reg[4] == COIL_ON_HI); // [R10]
      for (int i = 0; i < MAX_COILS; i++) begin
         if (wr_coils && i < cnt && (int'(start) + i) < NUM_COILS)
            coils_next[int'(start) + i] = wdata[i];          // [R16]
      end
   end

   // Main sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_RX;
         qlen_reg  <= 4'd0;
         bad_reg   <= 1'b0;
         crc_reg   <= CRC_PRESET;
         rlen_reg  <= 4'd0;
         ridx_reg  <= 4'd0;
         wait_reg  <= 18'd0;
         coils     <= '0;
         run_cmd   <= 1'b0;
         tx_valid  <= 1'b0;
         tx_byte   <= '0;
      end else begin
         case (state_reg)
            S_RX: begin
               if (rx_error)
                  bad_reg <= 1'b1;                           // [R20]
               if (pop) begin
                  if (buf_q[0].first) begin
                     crc_reg  <= crc_step(CRC_PRESET, buf_q[0].data); // [R21]
                     qlen_reg <= 4'd1;
                     bad_reg  <= rx_error;
                  end else begin
                     crc_reg  <= crc_step(crc_reg, buf_q[0].data);    // [R17]
                     if (qlen_reg == 4'd15)
                        bad_reg <= 1'b1;
                     else
                        qlen_reg <= qlen_reg + 4'd1;
                  end
                  if (buf_q[0].last)
                     state_reg <= S_EXEC;
               end
            end
            S_EXEC: begin
               if (frame_ok) begin
                  coils    <= coils_next;
                  run_cmd  <= (run_command_source == RUN_SRC_LINK) ? coils_next[0]
                                                                  : run_cmd; // [R12]
                  rlen_reg <= resp_len;
                  ridx_reg <= 4'd0;
                  wait_reg <= 18'(SILENT) + 18'(response_extra_wait);  // [R19]
                  crc_reg  <= CRC_PRESET;                              // [R21]
                  state_reg <= S_WAIT;
               end else begin
                  state_reg <= S_RX;                                   // [R5] [R20]
               end
            end
            S_WAIT: begin
               if (wait_reg <= 18'd1)
                  state_reg <= S_TX;
               else
                  wait_reg <= wait_reg - 18'd1;                        // [R19]
            end
            S_TX: begin
               if (!tx_valid || tx_ready) begin
                  if (ridx_reg < rlen_reg) begin
                     tx_byte  <= '{data: r_reg[ridx_reg], first: ridx_reg == 4'd0,
                                   last: 1'b0};
                     crc_reg  <= crc_step(crc_reg, r_reg[ridx_reg]);
                     tx_valid <= 1'b1;
                     ridx_reg <= ridx_reg + 4'd1;
                  end else if (ridx_reg == rlen_reg) begin
                     tx_byte  <= '{data: crc_reg[15:8], first: 1'b0, last: 1'b0}; // [R17]
                     tx_valid <= 1'b1;
                     ridx_reg <= ridx_reg + 4'd1;
                  end else if (ridx_reg == rlen_reg + 4'd1) begin
                     tx_byte  <= '{data: crc_reg[7:0], first: 1'b0, last: 1'b1};
                     tx_valid <= 1'b1;
                     ridx_reg <= ridx_reg + 4'd1;
                  end else begin
                     tx_valid  <= 1'b0;
                     state_reg <= S_RX;
                  end
               end
            end
            default: state_reg <= S_RX;
         endcase
      end
   end

   // Response image and register store, latched at execution
   always_ff @(posedge clk) begin
      if (state_reg == S_RX && pop && qlen_reg < 4'd12 && !buf_q[0].first)
         q_reg[qlen_reg] <= buf_q[0].data;
      else if (state_reg == S_RX && pop && buf_q[0].first)
         q_reg[0] <= buf_q[0].data;
      if (pop) begin
         crc_d1_reg <= buf_q[0].first ? CRC_PRESET : crc_reg;      // [R21]
         crc_d2_reg <= buf_q[0].first ? CRC_PRESET : crc_d1_reg;   // [R17]
         tail_reg   <= {tail_reg[7:0], buf_q[0].data};
      end
      if (state_reg == S_EXEC && frame_ok) begin
         r_reg <= resp;
         if (wr_reg)
            hreg[int'(start)] <= {q_reg[4], q_reg[5]};       // [R13]
      end
   end

   // Broadcast never produces an answer
   bcast_silent_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == S_EXEC && q_reg[0] == 8'h00) |=> state_reg == S_RX) // [R5]
      else $error("broadcast query answered");
   // Exception carries flagged function code
   exc_code_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == S_EXEC && frame_ok && resp_len == 4'd3) |-> resp[1][7]) // [R18]
      else $error("exception without flag");
   // Zero coil read is refused
   coil_cnt_a: assert property (@(posedge clk) disable iff (!rst_n)
      (fn == FN_RD_COILS && cnt == 16'd0) |-> resp[2] == EXC_DATA) // [R2]
      else $error("zero coil read accepted");
   // Bad frames dropped, run gate, output held under stall
   rx_err_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == S_EXEC && bad_reg) |=> state_reg == S_RX) // [R20]
      else $error("errored query answered");
   run_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      (run_command_source != RUN_SRC_LINK) |=> $stable(run_cmd)) // [R12]
      else $error("run command changed without link source");
   tx_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_byte))) // [R11]
      else $error("response byte dropped under stall");
endmodule : query_handler

// File: tb/master_model.sv
// Serial master model: feeds query bytes, collects answer bytes
`timescale 1ns/10ps
module master_model
   import query_pkg::*;
(
   input  wire logic  clk,
   output byte_s      rx_byte,
   output logic       rx_valid,
   input  wire logic  rx_ready,
   input  wire byte_s tx_byte,
   input  wire logic  tx_valid,
   output logic       tx_ready
);
   int cyc;     // Free cycle count for latency
   int t_last;  // Cycle of the final query byte
   int t_first; // Cycle of the first answer byte

   // Cycle counter
   always @(posedge clk) cyc <= cyc + 1;

   // Idle values at time zero
   initial begin
      cyc      = 0;
      rx_byte  = '0;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end

   // Check word over a byte list
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF; // Preset all ones
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1); // LSB first, reflected
         end
      end
      return c;
   endfunction : crc16

   // Send one query; bad corrupts the check word
   task automatic send(input logic [7:0] q[$], input bit bad);
      logic [15:0] c;
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[15:8]); // High byte first
      q.push_back(c[7:0]);
      foreach (q[i]) begin
         @(negedge clk);
         rx_byte  = '{data: q[i], first: (i == 0), last: (i == q.size() - 1)};
         rx_valid = 1'b1;
         // Hold until the buffer takes it
         while (!rx_ready) @(negedge clk);
         @(posedge clk);
         t_last = cyc;
      end
      @(negedge clk);
      rx_valid = 1'b0;
      // Released bus shows no stale value
      rx_byte  = '{data: ~q[q.size() - 1], first: 1'b0, last: 1'b0};
   endtask : send

   // Collect one answer; stall drops ready every other cycle
   task automatic recv(output logic [7:0] r[$], input bit stall, input int limit);
      int n;
      r       = {};
      n       = 0;
      t_first = -1;
      while (n < limit) begin
         @(negedge clk);
         n++;
         tx_ready = !stall || cyc[0];
         if (tx_valid && t_first < 0) t_first = cyc;
         if (tx_valid && tx_ready) begin
            r.push_back(tx_byte.data);
            if (tx_byte.last) break;
         end
      end
      @(negedge clk);
      tx_ready = 1'b0;
   endtask : recv
endmodule : master_model

// File: tb/testbench.sv
// Self-checking bench for the query handler
`timescale 1ns/10ps
module testbench;
   import query_pkg::*;
   localparam int         NC  = 12;    // Small range reaches out-of-range coils
   localparam int         SIL = 20;    // Short silent interval keeps run brief
   localparam logic [7:0] ME  = 8'h0A; // Own station address
   localparam logic [7:0] Z   = 8'h00;
   localparam logic [7:0] F   = 8'hFF;
   logic          clk, rst_n, rx_valid, rx_ready, rx_error, tx_valid, tx_ready, run_cmd;
   logic [7:0]    run_src;
   logic [15:0]   xwait;
   byte_s         rx_byte, tx_byte;
   logic [NC-1:0] coils;
   logic [7:0]    r[$];
   int            n_mismatch, check_count;

   query_handler #(.NUM_COILS(NC), .SILENT(SIL)) DUT (.clk(clk), .rst_n(rst_n), .slave_addr(ME),
      .run_command_source(run_src), .response_extra_wait(xwait), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_error(rx_error), .tx_byte(tx_byte),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .coils(coils), .run_cmd(run_cmd));

   master_model m (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));

   // One comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Query out, answer back, compared byte by byte with its latency
   task automatic xfer(input logic [7:0] q[$], input logic [7:0] e[$], input bit stall);
      logic [15:0] c;
      int          lat;
      m.send(q, 1'b0);
      m.recv(r, stall, 600);
      c = m.crc16(e);
      e.push_back(c[15:8]);
      e.push_back(c[7:0]);
      lat = m.t_first - m.t_last;
      chk(r.size(), e.size());
      foreach (e[i]) chk(r[i], e[i]);
      chk((lat >= SIL + int'(xwait)) && (lat <= SIL + int'(xwait) + 5), 1);
   endtask : xfer

   // Multi-coil write then read across the range end
   task automatic t_coils();
      xfer('{ME, 8'h0F, Z, Z, Z, 8'h0C, 8'h02, 8'hA5, 8'h0C}, '{ME, 8'h0F, Z, Z, Z, 8'h0C}, 0);
      chk(coils, 12'hCA5);
      xfer('{ME, 8'h01, Z, 8'h08, Z, 8'h08}, '{ME, 8'h01, 8'h01, 8'h0C}, 1);
      xfer('{ME, 8'h01, Z, Z, Z, Z}, '{ME, 8'h81, 8'h03}, 0);
      xfer('{ME, 8'h01, Z, Z, Z, 8'h21}, '{ME, 8'h81, 8'h03}, 0);
   endtask : t_coils

   // Single coil on/off, run source gating
   task automatic t_coil();
      logic [7:0] hi;
      for (int k = 0; k < 3; k++) begin
         run_src = (k == 2) ? 8'h01 : 8'h03;
         hi      = (k == 1) ? Z : F;
         xfer('{ME, 8'h05, Z, Z, hi, Z}, '{ME, 8'h05, Z, Z, hi, Z}, 0);
         chk(coils[0], hi[0]);
         chk(run_cmd, k == 0);
      end
      run_src = 8'h03;
   endtask : t_coil

   // Register writes, then a stalled read with extra wait
   task automatic t_regs();
      xfer('{ME, 8'h06, Z, 8'h02, 8'h12, 8'h34}, '{ME, 8'h06, Z, 8'h02, 8'h12, 8'h34}, 0);
      xfer('{ME, 8'h06, Z, 8'h03, 8'hAB, 8'hCD}, '{ME, 8'h06, Z, 8'h03, 8'hAB, 8'hCD}, 0);
      xwait = 16'h0007;
      xfer('{ME, 8'h03, Z, 8'h02, Z, 8'h02}, '{ME, 8'h03, 8'h04, 8'h12, 8'h34, 8'hAB, 8'hCD}, 1);
      xwait = 16'h0000;
   endtask : t_regs

   // Loopback echo and a refused subcode
   task automatic t_loop();
      xfer('{ME, 8'h08, Z, Z, 8'h5A, 8'hC3}, '{ME, 8'h08, Z, Z, 8'h5A, 8'hC3}, 0);
      m.send('{ME, 8'h08, Z, 8'h01, 8'h5A, 8'hC3}, 1'b0);
      m.recv(r, 1'b0, 600);
      chk(r[1], 8'h88);
   endtask : t_loop

   // Broadcast, foreign address, bad check word, line error: silence, no action
   task automatic t_silent();
      for (int k = 0; k < 4; k++) begin
         rx_error = (k == 3);
         m.send('{(k == 0) ? Z : (k == 1) ? 8'h0B : ME, 8'h05, Z, 8'h01, F, Z}, k == 2);
         rx_error = 1'b0;
         m.recv(r, 1'b0, SIL + 80);
         chk(r.size(), 0);
         chk(coils[1], 1'b0);
      end
   endtask : t_silent

   // Verdict and end of run
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   // Clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Watchdog well past the expected run
   initial begin
      #320000;
      n_mismatch++;
      end_of_test();
   end

   // Main sequence
   initial begin
      rst_n       = 1'b0;
      rx_error    = 1'b0;
      run_src     = 8'h03;
      xwait       = 16'h0000;
      n_mismatch  = 0;
      check_count = 0;
      repeat (16) @(negedge clk);
      chk(tx_valid, 0);
      chk(coils, 0);
      rst_n = 1'b1;
      t_silent();
      t_coils();
      t_coil();
      t_regs();
      t_loop();
      end_of_test();
   end
endmodule : testbench
